// File: hw/kbrx_pkg.sv
// package: shared constants and carrier types of the kernel bus read exerciser
package kbrx_pkg;
  localparam int unsigned KBRX_ADDR_W = 23;
  localparam logic [KBRX_ADDR_W-1:0] KBRX_ADDR_RST = 23'h000000;
  localparam logic [KBRX_ADDR_W-1:0] KBRX_ADDR_MAX = 23'h7fffff;
  localparam int unsigned KBRX_CLK_MHZ = 100;
  // status line one low time per read, in ns
  localparam int unsigned KBRX_STROBE_NS = 20;
  localparam int unsigned KBRX_STROBE_CYC =
    (KBRX_STROBE_NS * KBRX_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] KBRX_STROBE_CNT = 4'(KBRX_STROBE_CYC);

  typedef enum logic [4:0] {
    KBRX_IDLE  = 5'h01,
    KBRX_REQ   = 5'h02,
    KBRX_ISSUE = 5'h04,
    KBRX_WAIT  = 5'h08,
    KBRX_DONE  = 5'h10
  } kbrx_state_e;

  // bus outputs with their enables, high while driven
  typedef struct packed {
    logic [KBRX_ADDR_W-1:0] addr;
    logic addr_oe;
    logic status_line_zero_n;
    logic status_line_one_n;
    logic code_intack_select;
    logic mem_io_select;
    logic ctrl_oe;
  } kbrx_bus_s;

  // strap inputs
  typedef struct packed {
    logic stimulus_mode_select;
    logic wait_state_select;
    logic addr_latch_select;
  } kbrx_strap_s;
endpackage

// File: hw/kbrx_addr_latch.sv
// address latch that captures the bus address on each latch enable
`timescale 1ns/1ps
module kbrx_addr_latch #(
  parameter int unsigned ADDR_W = 23
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ale_i,
  input wire logic enable_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  output logic [ADDR_W-1:0] latched_addr_bit_o,
  output logic latched_addr_oe_o
);
  logic [ADDR_W-1:0] held;
  logic [ADDR_W-1:0] next_held;

  always_comb begin
    next_held = held;
    if (ale_i) begin
      next_held = bus_addr_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      held <= '0;
    end else begin
      held <= next_held;
    end
  end

  // disabled outputs carry zero and are not driven
  assign latched_addr_bit_o = enable_i ? held : '0;
  assign latched_addr_oe_o = enable_i;

  property p_latch_capture;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      ale_i |=> held == $past(bus_addr_i);
  endproperty
  a_latch_capture: assert property (p_latch_capture)
    else $error("latched address missed the strobe");

  property p_latch_off;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      !enable_i |-> !latched_addr_oe_o && latched_addr_bit_o == '0;
  endproperty
  a_latch_off: assert property (p_latch_off)
    else $error("latched address active while deselected");
endmodule // kbrx_addr_latch

// File: hw/kbrx_exerciser.sv
// top of the kernel bus read exerciser
`timescale 1ns/1ps
// Function
// - in stimulus mode with bus held, issue back-to-back reads everywhere
// - counter drives word address bits 1..23; bit 0 is not driven
// - raise hold request; drive nothing until grant acknowledge arrives
// - after grant hold status zero and code/intack low; pulse status one
// - memory/io select held high during exerciser cycles
// - status one strobes last a fixed KBRX_STROBE_NS (two cycles); next read waits for ready
// - assert address direction override while supplying addresses
// - wait-state select gives zero or one wait state per access
// - only stimulus mode starts bus activity; without it the bus is freed after any pending read, and only latched outputs drive
// - latched address outputs active only when latch select is on
// - latched outputs capture bus address on each latch enable strobe
module kbrx_exerciser
  import kbrx_pkg::*;
#(
  parameter int unsigned ADDR_W = KBRX_ADDR_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire kbrx_pkg::kbrx_strap_s strap_i,
  input wire logic bus_grant_ack_i,
  input wire logic system_ready_n_i,
  input wire logic ale_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  output logic bus_hold_req_o,
  output logic addr_dir_override_o,
  output kbrx_pkg::kbrx_bus_s bus_o,
  output logic [ADDR_W-1:0] latched_addr_bit_o,
  output logic latched_addr_oe_o
);
  import kbrx_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // read sequencer
  // ------------------------------------------------------------
  kbrx_state_e state;
  kbrx_state_e next_state;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic wait_done;
  logic next_wait_done;
  logic hold_req;
  logic next_hold_req;
  logic s1_n;
  logic next_s1_n;
  logic own;
  logic next_own;

  always_comb begin
    next_state = state;
    next_addr = addr;
    next_cnt = cnt;
    next_wait_done = wait_done;
    next_hold_req = hold_req;
    next_s1_n = 1'b1;
    next_own = own;
    case (state)
      KBRX_IDLE: begin
        next_own = 1'b0;
        if (strap_i.stimulus_mode_select) begin
          next_hold_req = 1'b1;
          next_state = KBRX_REQ;
        end
      end
      KBRX_REQ: begin
        if (!strap_i.stimulus_mode_select) begin
          next_hold_req = 1'b0;
          next_state = KBRX_IDLE;
        end else if (bus_grant_ack_i) begin
          next_own = 1'b1;
          next_state = KBRX_ISSUE;
        end
      end
      KBRX_ISSUE: begin
        // a strobe starts only once the board reports ready
        if (!system_ready_n_i) begin
          next_s1_n = 1'b0;
          next_cnt = KBRX_STROBE_CNT;
          next_wait_done = !strap_i.wait_state_select;
          next_state = KBRX_WAIT;
        end
      end
      KBRX_WAIT: begin
        if (cnt > 4'h1) begin
          next_s1_n = 1'b0;
          next_cnt = cnt - 4'h1;
        end else if (!wait_done) begin
          next_wait_done = 1'b1;
        end else begin
          next_state = KBRX_DONE;
        end
      end
      KBRX_DONE: begin
        next_addr = (addr == KBRX_ADDR_MAX) ? KBRX_ADDR_RST
                                            : addr + 23'h000001;
        if (!strap_i.stimulus_mode_select || !bus_grant_ack_i) begin
          next_hold_req = 1'b0;
          next_own = 1'b0;
          next_state = KBRX_IDLE;
        end else begin
          next_state = KBRX_ISSUE;
        end
      end
      default: begin
        next_state = KBRX_IDLE;
        next_hold_req = 1'b0;
        next_own = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= KBRX_IDLE;
      addr <= KBRX_ADDR_RST;
      cnt <= 4'h0;
      wait_done <= 1'b0;
      hold_req <= 1'b0;
      s1_n <= 1'b1;
      own <= 1'b0;
    end else if (!rst_sync) begin
      state <= KBRX_IDLE;
      addr <= KBRX_ADDR_RST;
      cnt <= 4'h0;
      wait_done <= 1'b0;
      hold_req <= 1'b0;
      s1_n <= 1'b1;
      own <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      cnt <= next_cnt;
      wait_done <= next_wait_done;
      hold_req <= next_hold_req;
      s1_n <= next_s1_n;
      own <= next_own;
    end
  end

  // ------------------------------------------------------------
  // bus drive
  // ------------------------------------------------------------
  // enables depend on ownership only, so nothing drives before grant
  always_comb begin
    bus_o.addr = own ? addr : '0;
    bus_o.addr_oe = own;
    bus_o.status_line_zero_n = 1'b0;
    bus_o.code_intack_select = 1'b0;
    bus_o.status_line_one_n = own ? s1_n : 1'b1;
    bus_o.mem_io_select = own;
    bus_o.ctrl_oe = own;
  end

  assign bus_hold_req_o = hold_req;
  assign addr_dir_override_o = own;

  // ------------------------------------------------------------
  // latched address view
  // ------------------------------------------------------------
  kbrx_addr_latch #(
    .ADDR_W(ADDR_W)
  ) u_latch (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_sync),
    .ale_i(ale_i),
    .enable_i(strap_i.addr_latch_select),
    .bus_addr_i(bus_addr_i),
    .latched_addr_bit_o(latched_addr_bit_o),
    .latched_addr_oe_o(latched_addr_oe_o)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_grant;
    bus_hold_req_o && bus_grant_ack_i && state == KBRX_REQ &&
      strap_i.stimulus_mode_select;
  endsequence
  sequence s_owned;
    bus_o.ctrl_oe && addr_dir_override_o;
  endsequence

  property p_no_drive_before_grant;
    @(posedge ref_clk_i) disable iff (!rst_sync)
      state == KBRX_REQ |-> !bus_o.ctrl_oe && !bus_o.addr_oe;
  endproperty
  a_no_drive_before_grant: assert property (p_no_drive_before_grant)
    else $error("bus driven before grant");

  property p_take_bus;
    @(posedge ref_clk_i) disable iff (!rst_sync)
      s_grant |=> s_owned;
  endproperty
  a_take_bus: assert property (p_take_bus)
    else $error("bus not taken one cycle after grant");

  property p_static_lines;
    @(posedge ref_clk_i) disable iff (!rst_sync)
      bus_o.ctrl_oe |-> !bus_o.status_line_zero_n &&
        !bus_o.code_intack_select && bus_o.mem_io_select;
  endproperty
  a_static_lines: assert property (p_static_lines)
    else $error("status zero, code or memory select wrong");

  property p_ready_gate;
    @(posedge ref_clk_i) disable iff (!rst_sync)
      state == KBRX_ISSUE && system_ready_n_i |=> s1_n;
  endproperty
  a_ready_gate: assert property (p_ready_gate)
    else $error("read started without ready");

  property p_strobe;
    @(posedge ref_clk_i) disable iff (!rst_sync)
      state == KBRX_ISSUE && !system_ready_n_i |=>
        !bus_o.status_line_one_n [*2] ##1 bus_o.status_line_one_n;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("status one strobe has wrong width");

  property p_wait_zero;
    @(posedge ref_clk_i) disable iff (!rst_sync)
      state == KBRX_ISSUE && !system_ready_n_i &&
        !strap_i.wait_state_select |=> ##2 state == KBRX_DONE;
  endproperty
  a_wait_zero: assert property (p_wait_zero)
    else $error("zero wait access too long");

  property p_step;
    @(posedge ref_clk_i) disable iff (!rst_sync)
      state == KBRX_DONE |=>
        addr == (($past(addr) == KBRX_ADDR_MAX) ? KBRX_ADDR_RST
                                                : $past(addr) + 23'h000001);
  endproperty
  a_step: assert property (p_step)
    else $error("address counter did not step");

  property p_loop;
    @(posedge ref_clk_i) disable iff (!rst_sync)
      state == KBRX_DONE && strap_i.stimulus_mode_select &&
        bus_grant_ack_i |=> state == KBRX_ISSUE;
  endproperty
  a_loop: assert property (p_loop)
    else $error("read sequence stopped");

  property p_passive;
    @(posedge ref_clk_i) disable iff (!rst_sync)
      state == KBRX_IDLE && !strap_i.stimulus_mode_select |=>
        !bus_hold_req_o && !bus_o.ctrl_oe;
  endproperty
  a_passive: assert property (p_passive)
    else $error("passive card drove the bus");

  property p_reset_clear;
    @(posedge ref_clk_i) !rst_sync |=>
      !bus_hold_req_o && !bus_o.ctrl_oe && addr == KBRX_ADDR_RST;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset did not clear exerciser");
endmodule // kbrx_exerciser

// File: tb/kbrx_cpu_model.sv
// processor board model: grants the bus and paces reads with ready
`timescale 1ns/1ps
module kbrx_cpu_model (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic hold_req_i,
  input wire logic stall_i,
  output logic grant_o,
  output logic ready_n_o
);
  // ---------------------------------------------------------------
  // grant and ready
  // ---------------------------------------------------------------
  // grant one cycle after hold: the processor floats its bus first
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      grant_o <= 1'b0;
    end else begin
      grant_o <= hold_req_i;
    end
  end
  // ready stays low unless the bench asks for a slow answer
  assign ready_n_o = stall_i;
endmodule // kbrx_cpu_model

// File: tb/kernel_bus_read_exerciser_test.sv
// self-checking bench for the kernel bus read exerciser
`timescale 1ns/1ps
module kernel_bus_read_exerciser_test;
  import kbrx_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  kbrx_strap_s strap = '0;
  logic stall = 1'b0;
  logic ale = 1'b0;
  logic [KBRX_ADDR_W-1:0] baddr = '0;
  logic hold, grant, ready_n, ovr, loe;
  kbrx_bus_s bus;
  logic [KBRX_ADDR_W-1:0] lat;
  int bad_count = 0;
  int comparisons = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  kbrx_exerciser kbrx_exerciser_inst (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .strap_i(strap),
    .bus_grant_ack_i(grant), .system_ready_n_i(ready_n), .ale_i(ale),
    .bus_addr_i(baddr), .bus_hold_req_o(hold), .addr_dir_override_o(ovr),
    .bus_o(bus), .latched_addr_bit_o(lat), .latched_addr_oe_o(loe)
  );
  kbrx_cpu_model kbrx_cpu_model_inst (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .hold_req_i(hold),
    .stall_i(stall), .grant_o(grant), .ready_n_o(ready_n)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // waits for hold, checks the bus is still untouched, then for ownership
  task automatic wait_own();
    int n;
    n = 0;
    while (hold !== 1'b1 && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk(bus.ctrl_oe === 1'b0 && bus.addr_oe === 1'b0, "early");
    while (bus.ctrl_oe !== 1'b1 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
  endtask

  // next status one strobe: its address and low width in cycles
  task automatic strobe(output int w, output logic [KBRX_ADDR_W-1:0] a);
    int n;
    n = 0;
    while (bus.status_line_one_n !== 1'b0 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    a = bus.addr;
    w = 0;
    while (bus.status_line_one_n === 1'b0 && w < 40) begin
      @(negedge ref_clk_i);
      w++;
    end
  endtask

  task automatic release_bus();
    strap = '0;
    repeat (12) @(negedge ref_clk_i);
    chk({hold, bus.ctrl_oe, ovr} === 3'h0, "release");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_latch();
    strap = '{1'b0, 1'b0, 1'b1};
    baddr = 23'h5a5a5a;
    ale = 1'b1;
    @(negedge ref_clk_i);
    ale = 1'b0;
    baddr = 23'h2a5a5a;
    @(negedge ref_clk_i);
    chk(loe === 1'b1 && lat === 23'h5a5a5a, "latch");
    chk(hold === 1'b0 && bus.ctrl_oe === 1'b0, "passive");
    strap = '0;
    @(negedge ref_clk_i);
    chk(loe === 1'b0 && lat === '0, "latch off");
    $display("test latch done");
  endtask

  task automatic t_reads(input logic ws);
    int w, g;
    logic [KBRX_ADDR_W-1:0] a0, a1;
    strap = '{1'b1, ws, 1'b0};
    wait_own();
    chk(ovr === 1'b1 && bus.addr_oe === 1'b1, "override");
    chk(bus.status_line_zero_n === 1'b0, "status zero");
    chk(bus.code_intack_select === 1'b0, "code select");
    chk(bus.mem_io_select === 1'b1, "memory space");
    strobe(w, a0);
    chk(w == 2, "first strobe width");
    // the wait state lengthens the read, not the strobe: the high time
    // between strobes is the step cycle, the reissue cycle and any wait
    g = 0;
    while (bus.status_line_one_n !== 1'b0 && g < 40) begin
      @(negedge ref_clk_i);
      g++;
    end
    chk(g == 2 + int'(ws), "read spacing");
    strobe(w, a1);
    chk(w == 2, "strobe width");
    chk(a1 === a0 + 23'h000001, "address step");
    release_bus();
    $display("test reads with wait %0d done", ws);
  endtask

  task automatic t_stall();
    int w, lows;
    logic [KBRX_ADDR_W-1:0] a;
    stall = 1'b1;
    strap = '{1'b1, 1'b0, 1'b0};
    wait_own();
    lows = 0;
    repeat (10) begin
      @(negedge ref_clk_i);
      if (bus.status_line_one_n !== 1'b1) lows++;
    end
    chk(lows == 0, "strobe while not ready");
    stall = 1'b0;
    strobe(w, a);
    chk(w == 2, "strobe after ready");
    release_bus();
    $display("test stall done");
  endtask

  task automatic t_reset();
    int w;
    logic [KBRX_ADDR_W-1:0] a;
    strap = '{1'b1, 1'b0, 1'b0};
    wait_own();
    strobe(w, a);
    strobe(w, a);
    rst_b_i = 1'b0;
    @(negedge ref_clk_i);
    chk(hold === 1'b0 && bus.ctrl_oe === 1'b0, "reset release");
    chk(bus.addr_oe === 1'b0 && ovr === 1'b0, "reset address");
    repeat (2) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    wait_own();
    strobe(w, a);
    chk(a === '0, "counter cleared");
    release_bus();
    $display("test reset done");
  endtask

  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    t_latch();
    t_reads(1'b0);
    t_reads(1'b1);
    t_stall();
    t_reset();
    finish_test();
  end

  // whole run is about 130 cycles; 5000 means a hang
  initial begin
    #50000;
    bad_count++;
    finish_test();
  end
endmodule // kernel_bus_read_exerciser_test
